// [dv/sadc_ctrl_properties.sv]
`timescale 1ns/1ps
module sadc_ctrl_properties (
    // Clocks and reset
    input wire logic       i_sys_clk,
    input wire logic       i_rst_b,
    input wire logic       i_sclk,
    input wire logic       i_aclk,
    // Watched pins
    input wire logic       i_cs_b,
    input wire logic       o_dout_oe,
    input wire logic       o_sample,
    input wire logic [2:0] o_mux_pos,
    input wire logic       o_busy,
    input wire logic       o_pwr_down
);
    // ----------------------------------------
    // Conversion-clock fall counters
    // ----------------------------------------
    logic       acl_q_reg;
    logic [2:0] wait_n_reg;
    logic [6:0] conv_n_reg;
    wire        acl_fall = acl_q_reg & ~i_aclk;

    // Raw falls are counted, so the counts may lead the synchronised copy; the conversion count, started with busy, can also lag it by one.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acl_q_reg  <= 1'b0;
            wait_n_reg <= 3'h0;
            conv_n_reg <= 7'h00;
        end else begin
            acl_q_reg <= i_aclk;
            if (i_cs_b || o_busy) wait_n_reg <= 3'h0;
            else if (acl_fall && wait_n_reg != 3'h7) wait_n_reg <= wait_n_reg + 3'h1;
            if (!o_busy) conv_n_reg <= 7'h00;
            else if (acl_fall) conv_n_reg <= conv_n_reg + 7'h01;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    oe_wait_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_dout_oe) |-> wait_n_reg >= 3'h2)
        else $error("output enabled too early");
    oe_late_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b) !i_cs_b && wait_n_reg == 3'h5 |-> o_dout_oe)
        else $error("output not enabled in time");
    oe_off_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b) i_cs_b [*7] |-> !o_dout_oe)
        else $error("output driven while deselected");
    busy_start_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_busy) |-> i_cs_b && $past(i_cs_b, 3))
        else $error("conversion started inside a frame");
    conv_len_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b) $fell(o_busy) |-> conv_n_reg inside {[51:53]})
        else $error("conversion length wrong");
    pdn_idle_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_pwr_down) |-> !o_busy && i_cs_b)
        else $error("shutdown entered while not idle");
    sample_len_a: assert property (
        @(posedge i_sclk) disable iff (!i_rst_b) o_sample [*8] |-> 1'b0)
        else $error("sampling longer than seven cycles");
    mux_hold_a: assert property (
        @(posedge i_sclk) disable iff (!i_rst_b) o_sample && $past(o_sample) |-> $stable(o_mux_pos))
        else $error("channel moved while sampling");

    conv_done_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $fell(o_busy));
    pdn_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_pwr_down));
    frame_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_dout_oe));
endmodule

bind sadc_ctrl sadc_ctrl_properties u_sadc_ctrl_properties (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_aclk(i_aclk),
    .i_cs_b(i_cs_b), .o_dout_oe(o_dout_oe), .o_sample(o_sample), .o_mux_pos(o_mux_pos),
    .o_busy(o_busy), .o_pwr_down(o_pwr_down)
);

// [dv/sadc_host.sv]
`timescale 1ns/1ps
module sadc_host (
    // Clocks
    input  wire logic i_sys_clk,
    input  wire logic i_aclk,
    // Device serial port
    input  wire logic i_dout,
    input  wire logic i_dout_oe,
    output logic      o_cs_b,
    output logic      o_sclk,
    output logic      o_din
);
    // The shift clock stands low between frames, so the device sees no stray edges.
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_din  = 1'b0;
    end

    // ----------------------------------------
    // One chip-select cycle
    // ----------------------------------------
    task automatic xfer(input logic [7:0] c, input int n, output logic [15:0] w, output logic ok);
        w  = '0;
        ok = 1'b1;
        @(posedge i_sys_clk);
        o_cs_b <= 1'b0;
        // A third fall covers the device's input synchronisers.
        repeat (3) @(negedge i_aclk);
        #100;
        o_din = c[7];
        for (int k = 0; k < n; k++) begin
            #15 o_sclk = 1'b1;
            w[k] = i_dout;
            ok   = ok & i_dout_oe;
            #15 o_sclk = 1'b0;
            #3 o_din = (k < 7) ? c[6-k] : ~o_din;
        end
        @(posedge i_sys_clk);
        o_cs_b <= 1'b1;
        o_din  <= ~o_din;
    endtask

    task automatic rest();
        repeat (54) @(negedge i_aclk);
    endtask
endmodule

// [dv/test_serial_adc_control_interface.sv]
`timescale 1ns/1ps
module test_serial_adc_control_interface;
    import sadc_pkg::*;

    // ----------------------------------------
    // Pins and bookkeeping
    // ----------------------------------------
    logic             i_sys_clk, i_rst_b, i_aclk, i_cmp, i_sclk, i_cs_b, i_din;
    logic             o_dout, o_dout_oe, o_mux_com, o_sample, o_busy, o_pwr_down;
    logic [2:0]       o_mux_pos, o_mux_neg;
    logic [RES_W-1:0] o_dac_code, vin, last_res;
    logic [7:0]       last_cfg;
    int               n_errors, comparisons, samp_cnt;
    wire              dout_pin = o_dout_oe ? o_dout : 1'bz;
    logic [RES_W-1:0] corner_v [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};

    sadc_ctrl u_sadc_ctrl (
        .i_sys_clk, .i_rst_b, .i_sclk, .i_cs_b, .i_din, .o_dout, .o_dout_oe, .i_aclk,
        .i_cmp, .o_mux_pos, .o_mux_neg, .o_mux_com, .o_sample, .o_dac_code, .o_busy,
        .o_pwr_down
    );
    sadc_host u_sadc_host (
        .i_sys_clk, .i_aclk, .i_dout(dout_pin), .i_dout_oe(o_dout_oe),
        .o_cs_b(i_cs_b), .o_sclk(i_sclk), .o_din(i_din)
    );

    always #2 i_sys_clk = ~i_sys_clk;
    always #40 i_aclk = ~i_aclk;
    always @(posedge i_sys_clk) i_cmp <= (vin >= o_dac_code);
    always @(posedge i_sclk) if (o_sample === 1'b1) samp_cnt++;

    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [15:0] exp_word(input logic [7:0] c, input logic [11:0] r, int n);
        logic [4:0] len;
        exp_word = '0;
        len = (c[1:0] == WL_8) ? LEN_8 : (c[1:0] == WL_12) ? LEN_12 : LEN_16;
        for (int k = 0; k < 16; k++)
            if (k < n && k < 12 && k < len) exp_word[k] = c[CFG_MSBF] ? r[11-k] : r[k];
    endfunction

    function automatic logic [6:0] exp_mux(input logic [7:0] c);
        logic [2:0] ev;
        ev = {c[CFG_SELH:CFG_SELL], 1'b0};
        if (c[CFG_SGL]) exp_mux = {c[CFG_SELH:CFG_SELL], c[CFG_ODD], 3'h0, 1'b1};
        else exp_mux = {ev | {2'h0, c[CFG_ODD]}, ev | {2'h0, !c[CFG_ODD]}, 1'b0};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic frame(input logic [7:0] c, input int n);
        logic [15:0] w;
        logic        ok;
        logic        pd;
        int          i;
        pd = (n >= 8) && (c[1:0] == WL_PWRDN);
        samp_cnt = 0;
        u_sadc_host.xfer(c, n, w, ok);
        chk("dout_oe", 16'h0001, {15'h0000, ok});
        chk("word", exp_word(last_cfg, last_res, n), w);
        if (n >= 8) begin
            chk("mux", 16'(exp_mux(c)), 16'({o_mux_pos, o_mux_neg, o_mux_com}));
            chk("sample", 16'h0007, 16'(samp_cnt));
        end
        if (n >= 8 && !pd) begin
            for (i = 0; i < 40 && o_busy !== 1'b1; i++) @(posedge i_sys_clk);
            chk("busy_rise", 16'h0001, {15'h0000, o_busy});
            if (o_busy !== 1'b1) wrap_up();
            last_cfg = c;
            last_res = c[CFG_UNI] ? vin : vin ^ SAR_START;
        end
        u_sadc_host.rest();
        chk("busy", 16'h0000, {15'h0000, o_busy});
        chk("pwr_down", {15'h0000, pd}, {15'h0000, o_pwr_down});
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        logic [7:0] c;
        i_sys_clk = 1'b0;
        i_rst_b   = 1'b0;
        i_aclk    = 1'b0;
        i_cmp     = 1'b0;
        vin       = '0;
        last_res  = '0;
        last_cfg  = 8'h0E;
        n_errors  = 0;
        comparisons = 0;
        samp_cnt  = 0;
        void'($urandom(32'h7D1D579A));
        repeat (6) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        for (int i = 0; i < 12; i++) begin
            c = 8'($urandom);
            c[1:0] = 2'(i % 3 + 1);
            c[CFG_MSBF] = i[1];
            c[CFG_UNI] = i[2];
            @(posedge i_sys_clk);
            vin <= corner_v[i % 4];
            frame(c, 16);
        end
        frame(8'hF0, 16);
        frame(8'h8D, 3);
        frame(8'h8D, 16);
        for (int i = 0; i < 25; i++) begin
            @(posedge i_sys_clk);
            vin <= 12'($urandom);
            frame(8'($urandom), 16);
        end
        wrap_up();
    end

    // A hang anywhere ends the run as a mismatch.
    initial begin
        #400000;
        n_errors++;
        $display("ERROR watchdog expected finish seen hang");
        wrap_up();
    end
endmodule

// [logic/sadc_ctrl.sv]
`timescale 1ns/1ps
module sadc_ctrl
    import sadc_pkg::*;
(
    // System clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_b,
    // Serial port
    input  wire logic                       i_sclk,
    input  wire logic                       i_cs_b,
    input  wire logic                       i_din,
    output logic                            o_dout,
    output logic                            o_dout_oe,
    // Conversion clock and comparator
    input  wire logic                       i_aclk,
    input  wire logic                       i_cmp,
    // Analog front end control
    output logic      [2:0]                 o_mux_pos,
    output logic      [2:0]                 o_mux_neg,
    output logic                            o_mux_com,
    output logic                            o_sample,
    output logic      [sadc_pkg::RES_W-1:0] o_dac_code,
    // Status
    output logic                            o_busy,
    output logic                            o_pwr_down
);
    import sadc_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [6:0] mux_decode(input logic [3:0] addr);
        logic [2:0] even;
        even = {addr[1:0], 1'b0};
        if (addr[3]) begin
            mux_decode = {even | {2'h0, addr[2]}, 3'h0, 1'b1};
        end else if (addr[2]) begin
            mux_decode = {even | 3'h1, even, 1'b0};
        end else begin
            mux_decode = {even, even | 3'h1, 1'b0};
        end
    endfunction

    function automatic logic [CNT_W-1:0] word_len(input logic [1:0] wl);
        if (wl == WL_8) begin
            word_len = LEN_8;
        end else if (wl == WL_12) begin
            word_len = LEN_12;
        end else begin
            word_len = LEN_16;
        end
    endfunction

    // ----------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_b_reg;
    logic cs_b_s;
    logic aclk_s;
    logic cmp_s;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_b_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_b_reg    <= rst_meta_reg;
        end
    end

    sadc_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
        .i_clk   (i_sys_clk),
        .i_rst_b (rst_b_reg),
        .i_async ({i_cs_b, i_aclk, i_cmp}),
        .o_sync  ({cs_b_s, aclk_s, cmp_s})
    );

    // ----------------------------------------
    // Shift-clock domain
    // ----------------------------------------
    // Chip select high clears the frame counters; the link clock is idle then.
    logic [CNT_W-1:0] rcnt_reg;
    logic [CNT_W-1:0] ncnt_reg;
    logic [CFG_W-1:0] cfg_shift_reg;
    logic             cfg_tog_reg;
    logic             dout_sclk_reg;
    logic [RES_W-1:0] tx_res_reg;
    logic [CNT_W-1:0] tx_len_reg;
    logic             tx_msbf_reg;
    logic             first_bit_reg;
    logic [CNT_W-1:0] next_idx;

    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            rcnt_reg <= '0;
        end else if (rcnt_reg != CNT_SAT) begin
            rcnt_reg <= rcnt_reg + 5'h01;
        end
    end

    always_ff @(posedge i_sclk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            cfg_shift_reg <= '0;
            cfg_tog_reg   <= 1'b0;
        end else if (!i_cs_b && rcnt_reg < CFG_BITS) begin
            cfg_shift_reg <= {cfg_shift_reg[CFG_W-2:0], i_din};
            if (rcnt_reg == CFG_BITS - 5'h01) begin
                cfg_tog_reg <= ~cfg_tog_reg;
            end
        end
    end

    // The multiplexer follows the address as soon as its four bits are in.
    always_ff @(posedge i_sclk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            o_mux_pos <= 3'h0;
            o_mux_neg <= 3'h0;
            o_mux_com <= 1'b1;
        end else if (!i_cs_b && rcnt_reg == MUX_BITS - 5'h01) begin
            {o_mux_pos, o_mux_neg, o_mux_com} <=
                mux_decode({cfg_shift_reg[2:0], i_din});
        end
    end

    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            o_sample <= 1'b0;
        end else begin
            o_sample <= (rcnt_reg >= ACQ_START - 5'h01) &&
                        (rcnt_reg < ACQ_START + ACQ_LEN - 5'h01);
        end
    end

    always_ff @(negedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            ncnt_reg <= '0;
        end else if (ncnt_reg != CNT_SAT) begin
            ncnt_reg <= ncnt_reg + 5'h01;
        end
    end

    assign next_idx = tx_msbf_reg ? (5'(RES_W - 1) - ncnt_reg - 5'h01) : (ncnt_reg + 5'h01);

    // Bits past the twelve result bits fill with zero; bits past the word length stay low.
    always_ff @(negedge i_sclk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            dout_sclk_reg <= 1'b0;
        end else if (ncnt_reg + 5'h01 < tx_len_reg && ncnt_reg + 5'h01 < 5'(RES_W)) begin
            dout_sclk_reg <= tx_res_reg[next_idx[3:0]];
        end else begin
            dout_sclk_reg <= 1'b0;
        end
    end

    // The first bit must be valid before any shift-clock edge, so the system side supplies it.
    assign o_dout = (ncnt_reg == '0) ? first_bit_reg : dout_sclk_reg;

    // ----------------------------------------
    // Configuration crossing
    // ----------------------------------------
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic tog_prev_reg;
    logic cfg_seen_reg;
    logic cfg_evt;

    always_ff @(posedge i_sys_clk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
            tog_prev_reg <= 1'b0;
        end else begin
            tog_meta_reg <= cfg_tog_reg;
            tog_sync_reg <= tog_meta_reg;
            tog_prev_reg <= tog_sync_reg;
        end
    end

    assign cfg_evt = tog_sync_reg ^ tog_prev_reg;

    // ----------------------------------------
    // Control state machine
    // ----------------------------------------
    sadc_state_t      state_reg;
    logic             aclk_prev_reg;
    logic             aclk_fall;
    logic [1:0]       fall_cnt_reg;
    logic [5:0]       conv_cnt_reg;
    logic [CFG_W-1:0] cfg_reg;
    logic [RES_W-1:0] res;
    logic [3:0]       bit_pos;

    assign aclk_fall = aclk_prev_reg & ~aclk_s;
    assign bit_pos   = 4'(RES_W - 1) - conv_cnt_reg[5:2];

    always_ff @(posedge i_sys_clk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            aclk_prev_reg <= 1'b0;
        end else begin
            aclk_prev_reg <= aclk_s;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            state_reg    <= ST_IDLE;
            fall_cnt_reg <= 2'h0;
            cfg_seen_reg <= 1'b0;
            cfg_reg      <= '0;
            o_dout_oe    <= 1'b0;
            o_pwr_down   <= 1'b0;
            o_busy       <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE, ST_SLEEP: begin
                    if (!cs_b_s) begin
                        state_reg    <= ST_WAIT;
                        fall_cnt_reg <= 2'h0;
                    end
                end
                ST_WAIT: begin
                    if (cs_b_s) begin
                        state_reg <= o_pwr_down ? ST_SLEEP : ST_IDLE;
                    end else if (aclk_fall) begin
                        fall_cnt_reg <= fall_cnt_reg + 2'h1;
                        if (fall_cnt_reg + 2'h1 == CS_WAIT_FALLS) begin
                            state_reg    <= ST_FRAME;
                            o_dout_oe    <= 1'b1;
                            o_pwr_down   <= 1'b0;
                            cfg_seen_reg <= 1'b0;
                        end
                    end
                end
                ST_FRAME: begin
                    if (cfg_evt) begin
                        cfg_seen_reg <= 1'b1;
                    end
                    if (cs_b_s) begin
                        o_dout_oe <= 1'b0;
                        if (cfg_seen_reg || cfg_evt) begin
                            cfg_reg <= cfg_shift_reg;
                            if (cfg_shift_reg[CFG_WLH:CFG_WLL] == WL_PWRDN) begin
                                state_reg  <= ST_SLEEP;
                                o_pwr_down <= 1'b1;
                            end else begin
                                state_reg <= ST_CONV;
                                o_busy    <= 1'b1;
                            end
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_CONV: begin
                    if (aclk_fall && conv_cnt_reg == CONV_ACLK - 6'h01) begin
                        state_reg <= ST_IDLE;
                        o_busy    <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Successive approximation
    // ----------------------------------------
    // Four conversion clocks per bit leave settling time; the last four close the cycle.
    always_ff @(posedge i_sys_clk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            conv_cnt_reg <= 6'h00;
            o_dac_code   <= SAR_START;
        end else if (state_reg != ST_CONV) begin
            conv_cnt_reg <= 6'h00;
            o_dac_code   <= SAR_START;
        end else if (aclk_fall) begin
            conv_cnt_reg <= conv_cnt_reg + 6'h01;
            if (conv_cnt_reg[1:0] == BIT_DECIDE && conv_cnt_reg[5:2] < 4'(RES_W)) begin
                o_dac_code[bit_pos] <= cmp_s;
                if (bit_pos != 4'h0) begin
                    o_dac_code[bit_pos - 4'h1] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Result word for the next frame
    // ----------------------------------------
    // Offset binary from the array becomes two's complement by flipping the top bit.
    assign res = cfg_reg[CFG_UNI] ? o_dac_code :
                 {~o_dac_code[RES_W-1], o_dac_code[RES_W-2:0]};

    // The word only changes while chip select is high, so the link side sees it stable.
    always_ff @(posedge i_sys_clk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            tx_res_reg    <= RES_ZERO;
            tx_len_reg    <= LEN_12;
            tx_msbf_reg   <= 1'b1;
            first_bit_reg <= 1'b0;
        end else if (state_reg == ST_CONV && aclk_fall &&
                     conv_cnt_reg == CONV_ACLK - 6'h01) begin
            tx_res_reg    <= res;
            tx_len_reg    <= word_len(cfg_reg[CFG_WLH:CFG_WLL]);
            tx_msbf_reg   <= cfg_reg[CFG_MSBF];
            first_bit_reg <= cfg_reg[CFG_MSBF] ? res[RES_W-1] : res[0];
        end
    end

endmodule

// [logic/sadc_pkg.sv]
// Functional notes
// - Result word length chosen by host: 8, 12 or 16 bits.
// - Result shifted out MSB first or LSB first as host requested.
// - Bipolar results come out in two's complement automatically.
// - Unipolar gives 12-bit unsigned; bipolar gives 12-bit two's complement.
// - One of eight inputs or one of four pairs routed; single-ended or differential per request.
// - Power-down request word puts the idle device into shutdown.
// - Analog input is sampled for 7 shift-clock cycles in each exchange.
// - Conversion takes 52 conversion clocks; chip select stays high meanwhile.
// - Data changes after falling shift-clock edge, sampled on rising; full duplex.
// - Config byte taken on first eight rising edges; rest ignored until next frame.
// - Each result returns in the frame after the one that requested it.
// - After chip select falls, wait two falling conversion-clock edges before acting.
package sadc_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int RES_W    = 12;
    localparam int WORD_MAX = 16;
    localparam int CFG_W    = 8;
    localparam int CNT_W    = 5;

    // ----------------------------------------
    // Configuration word fields
    // ----------------------------------------
    localparam int CFG_SGL  = 7;
    localparam int CFG_ODD  = 6;
    localparam int CFG_SELH = 5;
    localparam int CFG_SELL = 4;
    localparam int CFG_UNI  = 3;
    localparam int CFG_MSBF = 2;
    localparam int CFG_WLH  = 1;
    localparam int CFG_WLL  = 0;

    localparam logic [1:0] WL_PWRDN = 2'h0;
    localparam logic [1:0] WL_8     = 2'h1;
    localparam logic [1:0] WL_12    = 2'h2;
    localparam logic [1:0] WL_16    = 2'h3;

    localparam logic [CNT_W-1:0] LEN_8  = 5'h08;
    localparam logic [CNT_W-1:0] LEN_12 = 5'h0C;
    localparam logic [CNT_W-1:0] LEN_16 = 5'h10;

    // ----------------------------------------
    // Serial timing in shift-clock edges
    // ----------------------------------------
    localparam logic [CNT_W-1:0] CFG_BITS  = 5'h08;
    localparam logic [CNT_W-1:0] MUX_BITS  = 5'h04;
    localparam logic [CNT_W-1:0] ACQ_START = 5'h04;
    localparam logic [CNT_W-1:0] ACQ_LEN   = 5'h07;
    localparam logic [CNT_W-1:0] CNT_SAT   = 5'h1F;

    // ----------------------------------------
    // Conversion timing in conversion-clock cycles
    // ----------------------------------------
    localparam logic [5:0] CONV_ACLK   = 6'h34;
    localparam logic [1:0] BIT_DECIDE  = 2'h3;
    localparam logic [1:0] CS_WAIT_FALLS = 2'h2;
    localparam logic [RES_W-1:0] SAR_START = 12'h800;
    localparam logic [RES_W-1:0] RES_ZERO  = 12'h000;

    // ----------------------------------------
    // Control states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_FRAME = 3'b010,
        ST_CONV  = 3'b011,
        ST_SLEEP = 3'b100
    } sadc_state_t;

endpackage

// [logic/sadc_sync.sv]
`timescale 1ns/1ps
module sadc_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change is taken only once the last two stages agree, which filters one-cycle glitches.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_sync[g] <= RST_VAL[g];
                end else if (s2_reg[g] == s3_reg[g]) begin
                    o_sync[g] <= s3_reg[g];
                end
            end
        end
    endgenerate

endmodule
